// *** qec_top.sv ***
// Purpose: Quadrature encoder position counter with Avalon-MM registers
// Assumes: Encoder phases arrive asynchronously; clk_sys at 125 MHz
// Notes: Pins are synchronised, edges found on clk_sys
//
// What this block does
// - Normal mode counts on count-clock rise; up when direction high, else down.
// - Override mode takes direction from the direction-invert bit: 1 up, 0 down.
// - Control bit 7 inverts the count-clock input before any use.
// - Without override, control bit 8 inverts the direction input.
// - Filter bit 10 drops clock rises without a direction pulse since the last.
// - Bit 5 raises an interrupt on each count-clock rising edge while enable bit 0 is set.
// - Bit 3 raises an interrupt on each counter underflow.
// - Bit 2 raises an interrupt on each counter overflow.
// - Counter operates only while enable bit 0 is set.
// - Counting follows encoder edges, not the register clock's own events.
// - Up past maximum wraps to zero; down past zero loads maximum.
// - Sticky flags set on edge, underflow, overflow; cleared by status read.
// - All enabled interrupt conditions are ORed onto one request line.
// - Clear-register write zeroes counter; preset-register write loads maximum.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module qec_top import qec_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic countClockInput,
  input wire logic directionInput,
  input wire logic [QEC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [QEC_BUS_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [QEC_BUS_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);

  // ==========================================================
  // Declarations
  logic [1:0] pinSync;
  qec_cfg_t cfg;
  qec_step_t step;

  qec_bus_t bus_reg;
  qec_bus_t bus_next;
  logic wait_reg;
  logic wait_next;
  logic [QEC_BUS_W-1:0] rdata_reg;
  logic [QEC_BUS_W-1:0] rdata_next;

  logic [QEC_DATA_W-1:0] control_reg;
  logic [QEC_DATA_W-1:0] control_next;
  logic [QEC_DATA_W-1:0] maximum_reg;
  logic [QEC_DATA_W-1:0] maximum_next;
  logic [QEC_DATA_W-1:0] position_reg;
  logic [QEC_DATA_W-1:0] position_next;
  logic [QEC_DATA_W-1:0] status_reg;
  logic [QEC_DATA_W-1:0] status_next;
  logic irq_reg;
  logic irq_next;

  logic doWrite;
  logic doRead;
  logic wrControl;
  logic wrMaximum;
  logic wrPosition;
  logic wrClear;
  logic wrPreset;
  logic rdStatus;
  logic stepValid;
  logic edgeEvent;
  logic overEvent;
  logic underEvent;
  logic [QEC_DATA_W-1:0] readMux;
  logic [QEC_DATA_W-1:0] flagMask;

  // ==========================================================
  // Byte-lane merge of a 16-bit register
  function automatic logic [QEC_DATA_W-1:0] laneMerge(
    input logic [QEC_DATA_W-1:0] oldVal,
    input logic [QEC_BUS_W-1:0] wdata,
    input logic [3:0] be
  );
    logic [QEC_DATA_W-1:0] result;
    result = oldVal;
    if (be[0]) begin
      result[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      result[15:8] = wdata[15:8];
    end
    return result;
  endfunction

  // ==========================================================
  // Pin synchroniser
  qec_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pinIn({directionInput, countClockInput}),
    .pinSync(pinSync)
  );

  // ==========================================================
  // Control fields
  always_comb begin
    cfg.filterEn = control_reg[QEC_CON_FILTER];
    cfg.dirInvert = control_reg[QEC_CON_DIR_INV];
    cfg.clkInvert = control_reg[QEC_CON_CLK_INV];
    cfg.dirOverride = control_reg[QEC_CON_DIR_OVR];
    cfg.edgeIrqEn = control_reg[QEC_CON_EDGE_IE];
    cfg.underIrqEn = control_reg[QEC_CON_UNDER_IE];
    cfg.overIrqEn = control_reg[QEC_CON_OVER_IE];
    cfg.enable = control_reg[QEC_CON_ENABLE];
  end

  // ==========================================================
  // Edge detection and filter
  qec_edge_unit u_edge (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clkIn(pinSync[0]),
    .dirIn(pinSync[1]),
    .cfg(cfg),
    .stepOut(step)
  );

  // ==========================================================
  // Bus handshake
  always_comb begin
    bus_next = bus_reg;
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    doWrite = 1'b0;
    doRead = 1'b0;
    case (bus_reg)
      QEC_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_next = QEC_BUS_ACK;
          wait_next = 1'b0;
          if (avs_read) begin
            rdata_next = {{(QEC_BUS_W-QEC_DATA_W){1'b0}}, readMux};
          end
        end
      end
      QEC_BUS_ACK: begin
        bus_next = QEC_BUS_IDLE;
        wait_next = 1'b1;
        doWrite = avs_write;
        doRead = avs_read;
      end
      default: begin
        bus_next = QEC_BUS_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Address decode
  always_comb begin
    wrControl = doWrite && (avs_address == QEC_OFS_CONTROL);
    wrMaximum = doWrite && (avs_address == QEC_OFS_MAXIMUM);
    wrPosition = doWrite && (avs_address == QEC_OFS_POSITION);
    wrClear = doWrite && (avs_address == QEC_OFS_CLEAR);
    wrPreset = doWrite && (avs_address == QEC_OFS_PRESET);
    rdStatus = doRead && (avs_address == QEC_OFS_STATUS);
  end

  // ==========================================================
  // Read multiplexer
  always_comb begin
    case (avs_address)
      QEC_OFS_CONTROL: begin
        readMux = control_reg;
      end
      QEC_OFS_STATUS: begin
        readMux = status_reg;
      end
      QEC_OFS_MAXIMUM: begin
        readMux = maximum_reg;
      end
      QEC_OFS_POSITION: begin
        readMux = position_reg;
      end
      default: begin
        readMux = '0;
      end
    endcase
  end

  // ==========================================================
  // Control and maximum registers
  always_comb begin
    control_next = control_reg;
    maximum_next = maximum_reg;
    if (wrControl) begin
      control_next = laneMerge(control_reg, avs_writedata, avs_byteenable) & QEC_CON_WMASK;
    end
    if (wrMaximum) begin
      maximum_next = laneMerge(maximum_reg, avs_writedata, avs_byteenable);
    end
  end

  // ==========================================================
  // Position counter
  always_comb begin
    stepValid = step.step & cfg.enable;
    edgeEvent = step.rise & cfg.enable;
    overEvent = 1'b0;
    underEvent = 1'b0;
    position_next = position_reg;
    if (stepValid) begin
      if (step.up) begin
        if (position_reg >= maximum_reg) begin
          position_next = '0;
          overEvent = 1'b1;
        end else begin
          position_next = position_reg + 16'h0001;
        end
      end else begin
        if (position_reg == '0) begin
          position_next = maximum_reg;
          underEvent = 1'b1;
        end else begin
          position_next = position_reg - 16'h0001;
        end
      end
    end
    if (wrPosition) begin
      position_next = laneMerge(position_reg, avs_writedata, avs_byteenable);
    end
    if (wrClear) begin
      position_next = '0;
    end
    if (wrPreset) begin
      position_next = maximum_reg;
    end
  end

  // ==========================================================
  // Status flags
  always_comb begin
    flagMask = '0;
    flagMask[QEC_STA_EDGE] = 1'b1;
    flagMask[QEC_STA_UNDER] = 1'b1;
    flagMask[QEC_STA_OVER] = 1'b1;
    status_next = status_reg;
    if (rdStatus) begin
      status_next = status_reg & ~(rdata_reg[QEC_DATA_W-1:0] & flagMask);
    end
    if (edgeEvent) begin
      status_next[QEC_STA_EDGE] = 1'b1;
    end
    if (underEvent) begin
      status_next[QEC_STA_UNDER] = 1'b1;
    end
    if (overEvent) begin
      status_next[QEC_STA_OVER] = 1'b1;
    end
    if (stepValid) begin
      status_next[QEC_STA_DIR] = step.up;
    end
  end

  // ==========================================================
  // Interrupt request
  always_comb begin
    irq_next = (cfg.edgeIrqEn & status_next[QEC_STA_EDGE])
      | (cfg.underIrqEn & status_next[QEC_STA_UNDER])
      | (cfg.overIrqEn & status_next[QEC_STA_OVER]);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_reg <= QEC_BUS_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= '0;
      control_reg <= QEC_RST_CONTROL;
      maximum_reg <= QEC_RST_MAXIMUM;
      position_reg <= QEC_RST_POSITION;
      status_reg <= QEC_RST_STATUS;
      irq_reg <= 1'b0;
    end else begin
      bus_reg <= bus_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      control_reg <= control_next;
      maximum_reg <= maximum_next;
      position_reg <= position_next;
      status_reg <= status_next;
      irq_reg <= irq_next;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign irq = irq_reg;

endmodule

// *** qec_pkg.sv ***
// Purpose: Shared constants and types for the quadrature encoder counter
// Assumes: 32-bit Avalon-MM slave, byte addresses, one aligned word per register
// Notes: Registers hold 16 bits in the low half; upper bits read as zero
package qec_pkg;

  // ==========================================================
  // Widths
  localparam int QEC_DATA_W = 16;
  localparam int QEC_ADDR_W = 8;
  localparam int QEC_BUS_W = 32;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] QEC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] QEC_OFS_STATUS = 8'h04;
  localparam logic [7:0] QEC_OFS_MAXIMUM = 8'h08;
  localparam logic [7:0] QEC_OFS_POSITION = 8'h0c;
  localparam logic [7:0] QEC_OFS_CLEAR = 8'h14;
  localparam logic [7:0] QEC_OFS_PRESET = 8'h18;

  // ==========================================================
  // Control field positions
  localparam int QEC_CON_ENABLE = 0;
  localparam int QEC_CON_OVER_IE = 2;
  localparam int QEC_CON_UNDER_IE = 3;
  localparam int QEC_CON_EDGE_IE = 5;
  localparam int QEC_CON_DIR_OVR = 6;
  localparam int QEC_CON_CLK_INV = 7;
  localparam int QEC_CON_DIR_INV = 8;
  localparam int QEC_CON_FILTER = 10;
  localparam logic [15:0] QEC_CON_WMASK = 16'h05ed;

  // ==========================================================
  // Status field positions
  localparam int QEC_STA_DIR = 0;
  localparam int QEC_STA_OVER = 1;
  localparam int QEC_STA_UNDER = 2;
  localparam int QEC_STA_EDGE = 4;

  // ==========================================================
  // Reset values
  localparam logic [15:0] QEC_RST_CONTROL = 16'h0000;
  localparam logic [15:0] QEC_RST_MAXIMUM = 16'hffff;
  localparam logic [15:0] QEC_RST_POSITION = 16'h0000;
  localparam logic [15:0] QEC_RST_STATUS = 16'h0000;

  // ==========================================================
  // Types
  typedef struct packed {
    logic filterEn;
    logic dirInvert;
    logic clkInvert;
    logic dirOverride;
    logic edgeIrqEn;
    logic underIrqEn;
    logic overIrqEn;
    logic enable;
  } qec_cfg_t;

  typedef struct packed {
    logic rise;
    logic step;
    logic up;
  } qec_step_t;

  typedef enum logic [0:0] {
    QEC_BUS_IDLE,
    QEC_BUS_ACK
  } qec_bus_t;

endpackage

// *** qec_sync2.sv ***
// Purpose: Two-flop synchroniser for encoder pins
// Assumes: Inputs asynchronous to clk_sys
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module qec_sync2 import qec_pkg::*; #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // ==========================================================
  // Register stages
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pinIn;
      sync_reg <= meta_reg;
    end
  end

  assign pinSync = sync_reg;

endmodule

// *** qec_edge_unit.sv ***
// Purpose: Input shaping, edge detection and filter for encoder phases
// Assumes: Inputs already synchronised to clk_sys
// Notes: One step record per accepted count-clock rising edge
`timescale 1ns/1ps
module qec_edge_unit import qec_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkIn,
  input wire logic dirIn,
  input qec_cfg_t cfg,
  output qec_step_t stepOut
);

  logic clkPrev_reg;
  logic clkPrev_next;
  logic dirPrev_reg;
  logic dirPrev_next;
  logic sawRise_reg;
  logic sawRise_next;
  logic sawFall_reg;
  logic sawFall_next;
  qec_step_t step_reg;
  qec_step_t step_next;
  logic clkEff;
  logic dirEff;
  logic rise;
  logic dirUp;
  logic dirDown;

  // ==========================================================
  // Next state
  always_comb begin
    clkEff = clkIn ^ cfg.clkInvert;
    dirEff = cfg.dirOverride ? cfg.dirInvert : (dirIn ^ cfg.dirInvert);
    rise = clkEff & ~clkPrev_reg;
    dirUp = dirIn & ~dirPrev_reg;
    dirDown = ~dirIn & dirPrev_reg;
    clkPrev_next = clkEff;
    dirPrev_next = dirIn;
    sawRise_next = rise ? dirUp : (sawRise_reg | dirUp);
    sawFall_next = rise ? dirDown : (sawFall_reg | dirDown);
    step_next.rise = rise;
    step_next.step = rise & (~cfg.filterEn | (sawRise_reg & sawFall_reg));
    step_next.up = dirEff;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clkPrev_reg <= 1'b0;
      dirPrev_reg <= 1'b0;
      sawRise_reg <= 1'b0;
      sawFall_reg <= 1'b0;
      step_reg <= '0;
    end else begin
      clkPrev_reg <= clkPrev_next;
      dirPrev_reg <= dirPrev_next;
      sawRise_reg <= sawRise_next;
      sawFall_reg <= sawFall_next;
      step_reg <= step_next;
    end
  end

  assign stepOut = step_reg;

endmodule

// *** qec_top_monitor.sv ***
// Purpose: Port checker for the encoder counter
// Assumes: One clock domain, clk_sys
// Notes: Shadows control and maximum from bus writes
`timescale 1ns/1ps
module qec_top_monitor import qec_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic countClockInput,
  input wire logic directionInput,
  input wire logic [QEC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [QEC_BUS_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [QEC_BUS_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq
);
  logic [15:0] ctlReg;
  logic [15:0] maxReg;
  logic [3:0] ageReg;
  logic [1:0] pinReg;
  wire done = (avs_read || avs_write) && !avs_waitrequest;
  wire rdAt = avs_read && !avs_waitrequest;
  wire wrAt = avs_write && !avs_waitrequest;
  wire ie = |(ctlReg & 16'h002c);
  wire mapped = avs_address inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18};
  // =====
  // Helper state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctlReg <= 16'h0000;
      maxReg <= 16'hffff;
      ageReg <= 4'hf;
      pinReg <= 2'h0;
    end else begin
      pinReg <= {countClockInput, directionInput};
      if (pinReg != {countClockInput, directionInput}) ageReg <= 4'h0;
      else if (ageReg != 4'hf) ageReg <= ageReg + 4'h1;
      if (wrAt && avs_address == QEC_OFS_CONTROL) ctlReg <= avs_writedata[15:0] & QEC_CON_WMASK;
      if (wrAt && avs_address == QEC_OFS_MAXIMUM) maxReg <= avs_writedata[15:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // =====
  // Assertions
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  a_unmapped_zero: assert property (rdAt && !mapped |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctl_reserved: assert property (rdAt && avs_address == 8'h00 |-> avs_readdata == {16'h0, ctlReg})
    else $error("control readback wrong");
  a_irq_masked: assert property (!ie && !$past(ie) |-> !irq)
    else $error("irq while masked");
  a_pos_range: assert property (rdAt && avs_address == 8'h0c |-> avs_readdata[15:0] <= maxReg)
    else $error("position above maximum");
  a_irq_fall: assert property ($fell(irq) |-> $past(done) || $past(done, 2))
    else $error("irq fell without access");
  a_irq_cause: assert property ($rose(irq) |-> ageReg < 4'ha || $past(done, 2) || $past(done, 3))
    else $error("irq rose without cause");
  c_irq_rise: cover property ($rose(irq));
  c_pos_read: cover property (rdAt && avs_address == 8'h0c);
  c_unmapped: cover property (rdAt && !mapped);
endmodule

bind qec_top qec_top_monitor MON (.clk_sys(clk_sys), .rst_b(rst_b),
  .countClockInput(countClockInput), .directionInput(directionInput),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

// *** qec_encoder_model.sv ***
// Purpose: Behavioural two-phase shaft encoder
// Assumes: One phase cycle spans 80 ns
// Notes: Phases stand still between moves
`timescale 1ns/1ps
module qec_encoder_model (
  output logic phaseA,
  output logic phaseB
);
  initial begin
    phaseA = 1'b0;
    phaseB = 1'b0;
  end
  // =====
  // Mode 0 forward, 1 reverse, 2 first phase alone
  task automatic move(input int n, input int mode);
    logic [7:0] seq;
    seq = (mode == 0) ? 8'h78 : (mode == 1) ? 8'hb4 : 8'ha0;
    #3;
    repeat (n) begin
      for (int i = 3; i >= 0; i--) begin
        {phaseA, phaseB} = seq[2*i +: 2];
        #20;
      end
    end
  endtask
endmodule

// *** qec_top_test.sv ***
// Purpose: Self-checking bench for the encoder counter
// Assumes: Bus master waits for waitrequest low at a rising edge
// Notes: Integer model predicts position, status and irq
`timescale 1ns/1ps
module qec_top_test import qec_pkg::*;;
  logic clk_sys, rst_b, avsRead, avsWrite, avsWaitrequest, irq, phaseA, phaseB;
  logic [7:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata, rd;
  logic [15:0] lfsr, sta, ctl;
  int errorCnt, checked, pos, maxv, testNo;

  qec_top DUT (.clk_sys(clk_sys), .rst_b(rst_b), .countClockInput(phaseA),
    .directionInput(phaseB), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(4'hf),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .irq(irq));
  qec_encoder_model ENC (.phaseA(phaseA), .phaseB(phaseB));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // =====
  // Helpers
  function automatic logic [15:0] nextRand();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic completeRun();
    $display("checked %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic checkVal(string name, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(bit wr, logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge clk_sys);
    end while (avsWaitrequest !== 1'b0);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic rdChk(string name, logic [7:0] a, logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    checkVal(name, exp, rd);
  endtask
  task automatic setCtl(logic [15:0] v);
    bus(1'b1, QEC_OFS_CONTROL, {16'h0, v & 16'hfffe});
    bus(1'b1, QEC_OFS_CONTROL, {16'h0, v});
    ctl = v;
  endtask
  // =====
  // Model
  function automatic void mstep(bit up);
    if (up && pos >= maxv) begin
      pos = 0;
      sta[1] = 1'b1;
    end else if (!up && pos == 0) begin
      pos = maxv;
      sta[2] = 1'b1;
    end else pos = up ? pos + 1 : pos - 1;
    sta[4] = 1'b1;
    sta[0] = up;
  endfunction
  task automatic move(int n, int mode);
    bit up;
    up = (mode == 0) ^ ctl[7] ^ ctl[8];
    if (ctl[6]) up = ctl[8];
    ENC.move(n, mode);
    repeat (10) @(posedge clk_sys);
    if (ctl[0] && !(ctl[10] && mode == 2)) repeat (n) mstep(up);
  endtask
  task automatic verify();
    logic [2:0] hit;
    hit = {ctl[5], ctl[3], ctl[2]} & {sta[4], sta[2], sta[1]};
    checkVal("irq", {31'h0, |hit}, {31'h0, irq});
    rdChk("position", QEC_OFS_POSITION, pos);
    rdChk("status", QEC_OFS_STATUS, {16'h0, sta});
    sta[4:1] = 4'h0;
    testNo++;
    $display("test %0d done", testNo);
  endtask
  // =====
  // Sequence
  initial begin
    rst_b = 1'b0;
    {avsRead, avsWrite, avsAddress, avsWritedata} = '0;
    lfsr = 16'h000e;
    {errorCnt, checked, pos, testNo} = '0;
    {sta, ctl} = '0;
    maxv = 65535;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdChk("control", QEC_OFS_CONTROL, 32'h0);
    rdChk("maximum", QEC_OFS_MAXIMUM, 32'hffff);
    rdChk("unmapped", 8'h10, 32'h0);
    verify();
    rd = {16'h0, nextRand()};
    maxv = rd[2:0] + 3;
    bus(1'b1, QEC_OFS_MAXIMUM, maxv);
    setCtl(16'h002d);
    move(3, 0);
    verify();
    move(5, 1);
    verify();
    move(maxv, 0);
    verify();
    setCtl(16'h00ad);
    move(2, 0);
    verify();
    setCtl(16'h012d);
    move(2, 0);
    verify();
    setCtl(16'h016d);
    move(2, 1);
    verify();
    setCtl(16'h006d);
    move(2, 0);
    verify();
    setCtl(16'h002c);
    move(2, 0);
    verify();
    bus(1'b1, QEC_OFS_PRESET, {16'h0, nextRand()});
    rdChk("preset", QEC_OFS_POSITION, maxv);
    bus(1'b1, QEC_OFS_CLEAR, {16'h0, nextRand()});
    rdChk("clear", QEC_OFS_POSITION, 32'h0);
    pos = 0;
    setCtl(16'h0001);
    move(1, 0);
    verify();
    setCtl(16'h0401);
    move(2, 2);
    rdChk("filtered", QEC_OFS_POSITION, pos);
    bus(1'b0, QEC_OFS_STATUS, 32'h0);
    sta[4:1] = 4'h0;
    setCtl(16'h0001);
    move(2, 2);
    verify();
    setCtl(16'h0005);
    move(1, 0);
    verify();
    setCtl(16'h0009);
    move(1, 1);
    verify();
    setCtl(16'h0021);
    move(1, 0);
    verify();
    bus(1'b1, QEC_OFS_CONTROL, 32'h0000f800);
    rdChk("reserved", QEC_OFS_CONTROL, 32'h0);
    completeRun();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errorCnt++;
    completeRun();
  end
endmodule
